// File: design/psd_decoder.sv
`timescale 1ns/10ps
module psd_decoder #(
  parameter logic [25:0] FAIL_WINDOW = 26'(psd_pkg::FAIL_WINDOW_CYC),
  parameter logic [25:0] ENGINE    = 26'(psd_pkg::ENGINE_CYC)
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  address,
  input  wire logic [15:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [15:0] read_data,
  input  wire logic        ocd_event,
  input  wire logic        scd_event,
  input  wire logic        load_detect_timeout_expired,
  output logic             discharge_overcurrent_latch,
  output logic             discharge_short_latch,
  output logic             load_detect_pin,
  output logic             load_detect_timeout_restart,
  output logic             charge_fet_off_pin,
  output logic             discharge_fet_off_pin,
  output logic             alert_pin,
  output logic             permanent_failure,
  output logic             link_single_wire
);

  typedef enum logic [1:0] {
    PSD_FAIL_IDLE  = 2'b00,
    PSD_FAIL_ARMED = 2'b01
  } psd_fail_t;

  typedef struct packed {
    logic [15:0] read_data;
    logic [15:0] control;
    logic [7:0]  comm_type;
    logic [7:0]  pending_ct;
    logic [2:0]  read_offset;
    logic        ocd_latch;
    logic        scd_latch;
    logic        ocd_clear_req;
    logic        scd_clear_req;
    logic        source_on;
    logic        restart_pulse;
    logic [2:0]  out_level;
    psd_fail_t   fail_state;
    logic [25:0] fail_timer;
    logic        perm_fail;
    logic        single_wire;
    logic [15:0] last_sub;
  } psd_state_t;

  psd_state_t state;
  psd_state_t next_state;
  logic       engine_tick;

  psd_engine_tick #(
    .PERIOD(ENGINE)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick (engine_tick)
  );

  // Byte of the identity readout at a given offset
  function automatic logic [7:0] psd_id_byte(input logic [15:0] sub, input logic [2:0] off);
    logic [7:0] b;
    b = 8'h00;
    if (sub == psd_pkg::SUB_DEVICE_NUMBER) begin
      unique case (off)
        3'h0: b = psd_pkg::ID_PRODUCT[7:0];
        3'h1: b = psd_pkg::ID_PRODUCT[15:8];
        default: b = 8'h00;
      endcase
    end else if (sub == psd_pkg::SUB_FIRMWARE_ID) begin
      unique case (off)
        3'h0: b = psd_pkg::ID_PRODUCT[15:8];
        3'h1: b = psd_pkg::ID_PRODUCT[7:0];
        3'h2: b = psd_pkg::ID_FW_VER[15:8];
        3'h3: b = psd_pkg::ID_FW_VER[7:0];
        3'h4: b = psd_pkg::ID_BUILD[15:8];
        3'h5: b = psd_pkg::ID_BUILD[7:0];
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction : psd_id_byte

  function automatic logic psd_privileged(input logic [1:0] sec);
    return (sec == psd_pkg::SEC_UNSEALED) || (sec == psd_pkg::SEC_FULL_ACCESS);
  endfunction : psd_privileged

  logic [1:0]  sec;
  logic [7:0]  active_time;
  logic [2:0]  out_cfg;
  logic        cmd_write;
  logic [15:0] sub;

  assign sec         = state.control[psd_pkg::CTL_SEC_LSB +: 2];
  assign active_time = state.control[psd_pkg::CTL_LOAD_TIME_LSB +: 8];
  assign out_cfg     = {state.control[psd_pkg::CTL_ALERT_OUT], state.control[psd_pkg::CTL_DSG_OUT],
                        state.control[psd_pkg::CTL_CHG_OUT]};
  assign cmd_write   = write_strobe && (address == psd_pkg::REG_COMMAND);
  assign sub         = write_data;

  always_comb begin
    next_state = state;
    next_state.restart_pulse = 1'b0;

    // Fault events set the latches; the set wins over an engine clear
    if (engine_tick) begin
      if (state.ocd_clear_req) begin
        next_state.ocd_latch     = 1'b0;
        next_state.ocd_clear_req = 1'b0;
      end
      if (state.scd_clear_req) begin
        next_state.scd_latch     = 1'b0;
        next_state.scd_clear_req = 1'b0;
      end
    end
    if (ocd_event) begin
      next_state.ocd_latch = 1'b1;
    end
    if (scd_event) begin
      next_state.scd_latch = 1'b1;
    end

    // Failure window runs out without the second word
    if (state.fail_state == PSD_FAIL_ARMED) begin
      if (state.fail_timer >= FAIL_WINDOW - 26'h1) begin
        next_state.fail_state = PSD_FAIL_IDLE;
      end else begin
        next_state.fail_timer = state.fail_timer + 26'h1;
      end
    end

    if (write_strobe) begin
      unique case (address)
        psd_pkg::REG_CONTROL:    next_state.control    = write_data;
        psd_pkg::REG_PENDING_CT: next_state.pending_ct = write_data[7:0];
        psd_pkg::REG_READ_OFFSET: next_state.read_offset = write_data[2:0];
        default: ;
      endcase
    end

    if (cmd_write) begin
      next_state.last_sub    = sub;
      next_state.read_offset = 3'h0;
      // Any command write other than the first word breaks the pair
      next_state.fail_state = PSD_FAIL_IDLE;
      unique case (sub)
        psd_pkg::SUB_OCD_CLEAR: next_state.ocd_clear_req = 1'b1;
        psd_pkg::SUB_SCD_CLEAR: next_state.scd_clear_req = 1'b1;
        psd_pkg::SUB_LOAD_RESTART: begin
          if (load_detect_timeout_expired) begin
            next_state.restart_pulse = 1'b1;
          end
        end
        psd_pkg::SUB_LOAD_ON: begin
          if (active_time == 8'h00) begin
            next_state.source_on = 1'b1;
          end
        end
        psd_pkg::SUB_LOAD_OFF: begin
          if (active_time == 8'h00) begin
            next_state.source_on = 1'b0;
          end
        end
        psd_pkg::SUB_CHG_OFF_LO, psd_pkg::SUB_DSG_OFF_LO, psd_pkg::SUB_ALERT_LOW: begin
          if (out_cfg[sub[1:0]]) begin
            next_state.out_level[sub[1:0]] = 1'b0;
          end
        end
        psd_pkg::SUB_CHG_OFF_HI, psd_pkg::SUB_DSG_OFF_HI, psd_pkg::SUB_ALERT_HIGH: begin
          if (out_cfg[sub[1:0]]) begin
            next_state.out_level[sub[1:0]] = 1'b1;
          end
        end
        psd_pkg::SUB_FAIL_FIRST: begin
          next_state.fail_state = PSD_FAIL_ARMED;
          next_state.fail_timer = 26'h0;
        end
        psd_pkg::SUB_FAIL_SECOND: begin
          if (state.fail_state == PSD_FAIL_ARMED) begin
            next_state.perm_fail = 1'b1;
          end
        end
        psd_pkg::SUB_SWAP_COMM: begin
          if (psd_privileged(sec)) begin
            next_state.comm_type   = state.pending_ct;
            next_state.single_wire = (state.pending_ct == psd_pkg::COMM_SINGLE_WIRE);
          end
        end
        psd_pkg::SUB_TO_TWO_WIRE: begin
          if (psd_privileged(sec)) begin
            next_state.comm_type   = psd_pkg::COMM_TWO_WIRE_FAST;
            next_state.single_wire = 1'b0;
          end
        end
        psd_pkg::SUB_TO_SINGLE_WIRE: begin
          if (psd_privileged(sec)) begin
            next_state.comm_type   = psd_pkg::COMM_SINGLE_WIRE;
            next_state.single_wire = 1'b1;
          end
        end
        default: ;
      endcase
    end

    next_state.read_data = 16'h0000;
    if (read_strobe) begin
      unique case (address)
        psd_pkg::REG_COMMAND:     next_state.read_data = state.last_sub;
        psd_pkg::REG_CONTROL:     next_state.read_data = state.control;
        psd_pkg::REG_STATUS:      next_state.read_data = {9'h000, state.fail_state == PSD_FAIL_ARMED,
                                                          state.perm_fail, state.single_wire, state.source_on,
                                                          state.scd_latch,
                                                          state.ocd_latch, 1'b0};
        psd_pkg::REG_COMM_TYPE:   next_state.read_data = {8'h00, state.comm_type};
        psd_pkg::REG_PENDING_CT:  next_state.read_data = {8'h00, state.pending_ct};
        psd_pkg::REG_READ_OFFSET: next_state.read_data = {13'h0000, state.read_offset};
        psd_pkg::REG_READ_DATA: begin
          next_state.read_data   = {8'h00, psd_id_byte(state.last_sub, state.read_offset)};
          // Auto-increment so a block read walks the bytes in order
          next_state.read_offset = state.read_offset + 3'h1;
        end
        default: next_state.read_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state            <= '0;
      state.control    <= psd_pkg::CTL_RESET;
      state.comm_type  <= psd_pkg::COMM_RESET;
      state.pending_ct <= psd_pkg::COMM_RESET;
      state.out_level  <= psd_pkg::OUT_LEVEL_RESET;
      state.fail_state <= PSD_FAIL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign read_data                   = state.read_data;
  assign discharge_overcurrent_latch = state.ocd_latch;
  assign discharge_short_latch       = state.scd_latch;
  assign load_detect_pin             = state.source_on;
  assign load_detect_timeout_restart = state.restart_pulse;
  assign charge_fet_off_pin          = state.out_level[0];
  assign discharge_fet_off_pin       = state.out_level[1];
  assign alert_pin                   = state.out_level[2];
  assign permanent_failure           = state.perm_fail;
  assign link_single_wire            = state.single_wire;
endmodule : psd_decoder

// File: design/psd_engine_tick.sv
`timescale 1ns/10ps
// Free-running divider giving one pulse per protection-engine pass
module psd_engine_tick #(
  parameter logic [25:0] PERIOD = 26'(psd_pkg::ENGINE_CYC)
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      tick
);
  typedef struct packed {
    logic [25:0] count;
    logic        tick;
  } psd_tick_state_t;

  psd_tick_state_t state;
  psd_tick_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count >= PERIOD - 26'h1) begin
      next_state.count = 26'h0;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 26'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule : psd_engine_tick

// File: design/psd_pkg.sv
package psd_pkg;

  // Subcommand codes handled by this decoder
  localparam logic [15:0] SUB_DEVICE_NUMBER  = 16'h0001;
  localparam logic [15:0] SUB_FIRMWARE_ID    = 16'h0002;
  localparam logic [15:0] SUB_OCD_CLEAR      = 16'h009b;
  localparam logic [15:0] SUB_SCD_CLEAR      = 16'h009c;
  localparam logic [15:0] SUB_LOAD_RESTART   = 16'h009d;
  localparam logic [15:0] SUB_LOAD_ON        = 16'h009e;
  localparam logic [15:0] SUB_LOAD_OFF       = 16'h009f;
  localparam logic [15:0] SUB_CHG_OFF_LO     = 16'h2800;
  localparam logic [15:0] SUB_DSG_OFF_LO     = 16'h2801;
  localparam logic [15:0] SUB_ALERT_LOW      = 16'h2802;
  localparam logic [15:0] SUB_CHG_OFF_HI     = 16'h2810;
  localparam logic [15:0] SUB_DSG_OFF_HI     = 16'h2811;
  localparam logic [15:0] SUB_ALERT_HIGH     = 16'h2812;
  localparam logic [15:0] SUB_FAIL_FIRST     = 16'h2857;
  localparam logic [15:0] SUB_FAIL_SECOND    = 16'h29a3;
  localparam logic [15:0] SUB_SWAP_COMM      = 16'h29bc;
  localparam logic [15:0] SUB_TO_TWO_WIRE    = 16'h29e7;
  localparam logic [15:0] SUB_TO_SINGLE_WIRE = 16'h7c40;

  // Communication-type setting values
  localparam logic [7:0] COMM_TWO_WIRE_FAST = 8'h08;
  localparam logic [7:0] COMM_SINGLE_WIRE   = 8'h03;
  localparam logic [7:0] COMM_RESET         = 8'h08;

  // Security states
  localparam logic [1:0] SEC_SEALED      = 2'h0;
  localparam logic [1:0] SEC_UNSEALED    = 2'h1;
  localparam logic [1:0] SEC_FULL_ACCESS = 2'h2;

  // Register offsets of the plain register port
  localparam logic [3:0] REG_COMMAND     = 4'h0;
  localparam logic [3:0] REG_CONTROL     = 4'h1;
  localparam logic [3:0] REG_STATUS      = 4'h2;
  localparam logic [3:0] REG_COMM_TYPE   = 4'h3;
  localparam logic [3:0] REG_PENDING_CT  = 4'h4;
  localparam logic [3:0] REG_READ_OFFSET = 4'h5;
  localparam logic [3:0] REG_READ_DATA   = 4'h6;

  // Control register fields
  localparam int CTL_SEC_LSB       = 0;
  localparam int CTL_CHG_OUT       = 2;
  localparam int CTL_DSG_OUT       = 3;
  localparam int CTL_ALERT_OUT     = 4;
  localparam int CTL_LOAD_TIME_LSB = 8;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // The three output pins idle high until a subcommand drives them
  localparam logic [2:0] OUT_LEVEL_RESET = 3'h7;

  // Identity values; arbitrary neutral values
  localparam logic [15:0] ID_PRODUCT = 16'h1234;
  localparam logic [15:0] ID_FW_VER  = 16'h0100;
  localparam logic [15:0] ID_BUILD   = 16'h0001;

  // Timing at 10 MHz
  localparam longint CLOCK_HZ         = 10000000;
  localparam longint FAIL_WINDOW_S    = 4;
  localparam longint FAIL_WINDOW_CYC  = FAIL_WINDOW_S * CLOCK_HZ;
  localparam longint ENGINE_PERIOD_S  = 1;
  localparam longint ENGINE_CYC       = ENGINE_PERIOD_S * CLOCK_HZ;
  localparam int     TIMER_W          = 26;

endpackage : psd_pkg

// File: tb/psd_decoder_props.sv
`timescale 1ns/10ps
module psd_decoder_props #(
  parameter logic [25:0] ENGINE = 26'(psd_pkg::ENGINE_CYC)
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [3:0]  address,
  input wire logic [15:0] write_data,
  input wire logic        write_strobe,
  input wire logic        ocd_event,
  input wire logic        load_detect_timeout_expired,
  input wire logic        discharge_overcurrent_latch,
  input wire logic        load_detect_pin,
  input wire logic        load_detect_timeout_restart,
  input wire logic        charge_fet_off_pin,
  input wire logic        alert_pin,
  input wire logic        permanent_failure,
  input wire logic        link_single_wire
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic   cmd = write_strobe && address == 4'h0;
  wire logic   fail_b = cmd && write_data == 16'h29a3;
  logic [15:0] ctl;
  logic        ocd_req;
  logic [26:0] ocd_wait;
  // Shadow of the control register, so pin and security checks know the configuration
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl      <= 16'h0000;
      ocd_req  <= 1'b0;
      ocd_wait <= 27'h0;
    end else begin
      if (write_strobe && address == 4'h1)
        ctl <= write_data;
      // A new overcurrent event re-arms the latch, so the check stops waiting on the pending clear
      ocd_req  <= (ocd_req || (cmd && write_data == 16'h009b)) && discharge_overcurrent_latch && !ocd_event;
      ocd_wait <= ocd_req ? ocd_wait + 27'h1 : 27'h0;
    end
  end
  property p_ocd_bound;
    ocd_wait <= 27'(ENGINE) + 27'h2;
  endproperty
  a_ocd_bound: assert property (p_ocd_bound)
    else $error("overcurrent latch clear overdue");
  property p_restart;
    cmd && write_data == 16'h009d |=> load_detect_timeout_restart == $past(load_detect_timeout_expired);
  endproperty
  a_restart: assert property (p_restart)
    else $error("load detect restart wrong");
  property p_source_on;
    cmd && write_data == 16'h009e && ctl[15:8] == 8'h00 |=> load_detect_pin;
  endproperty
  a_source_on: assert property (p_source_on)
    else $error("load detect force on missed");
  property p_source_auto;
    cmd && write_data[15:1] == 15'h004f && ctl[15:8] != 8'h00 |=> $stable(load_detect_pin);
  endproperty
  a_source_auto: assert property (p_source_auto)
    else $error("load detect forced under autonomous control");
  property p_chg_low;
    cmd && write_data == 16'h2800 && ctl[2] |=> !charge_fet_off_pin;
  endproperty
  a_chg_low: assert property (p_chg_low)
    else $error("charge off pin not driven low");
  property p_alert_high;
    cmd && write_data == 16'h2812 && ctl[4] |=> alert_pin;
  endproperty
  a_alert_high: assert property (p_alert_high)
    else $error("alert pin not driven high");
  property p_fail_cause;
    $rose(permanent_failure) |-> $past(fail_b);
  endproperty
  a_fail_cause: assert property (p_fail_cause)
    else $error("failure forced without second word");
  property p_link_single;
    cmd && write_data == 16'h7c40 && ctl[1:0] != 2'h0 |=> link_single_wire;
  endproperty
  a_link_single: assert property (p_link_single)
    else $error("single wire link not selected");
  property p_link_sealed;
    cmd && ctl[1:0] == 2'h0 && (write_data == 16'h7c40 || write_data == 16'h29e7 || write_data == 16'h29bc)
      |=> $stable(link_single_wire);
  endproperty
  a_link_sealed: assert property (p_link_sealed)
    else $error("link switched while sealed");
endmodule : psd_decoder_props

bind psd_decoder psd_decoder_props #(.ENGINE(ENGINE)) psd_decoder_props_inst (.clock(clock), .rst_n(rst_n),
  .address(address), .write_data(write_data), .write_strobe(write_strobe), .ocd_event(ocd_event),
  .load_detect_timeout_expired(load_detect_timeout_expired),
  .discharge_overcurrent_latch(discharge_overcurrent_latch),
  .load_detect_pin(load_detect_pin), .load_detect_timeout_restart(load_detect_timeout_restart),
  .charge_fet_off_pin(charge_fet_off_pin), .alert_pin(alert_pin), .permanent_failure(permanent_failure),
  .link_single_wire(link_single_wire));

// File: tb/psd_decoder_tb.sv
`timescale 1ns/10ps
module psd_decoder_tb;
  logic        clock;
  logic        rst_n;
  logic [3:0]  address;
  logic [15:0] write_data;
  logic [15:0] read_data;
  logic [15:0] rv;
  logic        write_strobe, read_strobe, ocd_event, scd_event, load_detect_timeout_expired;
  logic        ocd_latch, scd_latch, load_pin, load_restart, chg_pin, dsg_pin, alert, fail_out, single;
  int          errors;
  int          checks_done;
  psd_decoder #(.FAIL_WINDOW(26'h32), .ENGINE(26'h14)) psd_decoder_inst (.clock(clock), .rst_n(rst_n),
    .address(address), .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .ocd_event(ocd_event), .scd_event(scd_event),
    .load_detect_timeout_expired(load_detect_timeout_expired), .discharge_overcurrent_latch(ocd_latch),
    .discharge_short_latch(scd_latch), .load_detect_pin(load_pin), .load_detect_timeout_restart(load_restart),
    .charge_fet_off_pin(chg_pin), .discharge_fet_off_pin(dsg_pin), .alert_pin(alert),
    .permanent_failure(fail_out), .link_single_wire(single));
  psd_host psd_host_inst (.clock(clock), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic cmd(input logic [15:0] d);
    psd_host_inst.wr(4'h0, d);
    @(negedge clock);
  endtask : cmd
  task automatic ctl(input logic [15:0] d);
    psd_host_inst.wr(4'h1, d);
  endtask : ctl
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    psd_host_inst.rd(a, rv);
    chk(rv, exp);
  endtask : rdchk
  task automatic t_latch;
    @(posedge clock);
    ocd_event <= 1'b1;
    scd_event <= 1'b1;
    @(posedge clock);
    ocd_event <= 1'b0;
    scd_event <= 1'b0;
    cmd(16'h009b);
    repeat (22) @(negedge clock);
    chk({14'h0, ocd_latch, scd_latch}, 16'h0001);
    cmd(16'h009c);
    repeat (22) @(negedge clock);
    chk({14'h0, ocd_latch, scd_latch}, 16'h0000);
  endtask : t_latch
  task automatic t_load_detect;
    cmd(16'h009e);
    chk({15'h0, load_pin}, 16'h0001);
    cmd(16'h009f);
    chk({15'h0, load_pin}, 16'h0000);
    ctl(16'h0100);
    cmd(16'h009e);
    chk({15'h0, load_pin}, 16'h0000);
    cmd(16'h009d);
    chk({15'h0, load_restart}, 16'h0000);
    @(posedge clock);
    load_detect_timeout_expired <= 1'b1;
    cmd(16'h009d);
    chk({15'h0, load_restart}, 16'h0001);
  endtask : t_load_detect
  task automatic t_gpo;
    ctl(16'h001c);
    for (int i = 0; i < 3; i++) begin
      cmd(16'h2800 + 16'(i));
      chk({13'h0, chg_pin, dsg_pin, alert}, 16'h0007 ^ (16'h0004 >> i));
      cmd(16'h2810 + 16'(i));
      chk({13'h0, chg_pin, dsg_pin, alert}, 16'h0007);
    end
    ctl(16'h0000);
    cmd(16'h2800);
    chk({13'h0, chg_pin, dsg_pin, alert}, 16'h0007);
  endtask : t_gpo
  task automatic t_link;
    cmd(16'h7c40);
    chk({15'h0, single}, 16'h0000);
    ctl(16'h0001);
    cmd(16'h7c40);
    chk({15'h0, single}, 16'h0001);
    rdchk(4'h3, 16'h0003);
    cmd(16'h29e7);
    chk({15'h0, single}, 16'h0000);
    rdchk(4'h3, 16'h0008);
    psd_host_inst.wr(4'h4, 16'h0003);
    ctl(16'h0002);
    cmd(16'h29bc);
    chk({15'h0, single}, 16'h0001);
  endtask : t_link
  task automatic t_id;
    logic [47:0] fw;
    fw = {psd_pkg::ID_PRODUCT, psd_pkg::ID_FW_VER, psd_pkg::ID_BUILD};
    ctl(16'h0000);
    cmd(16'h0001);
    rdchk(4'h6, {8'h00, psd_pkg::ID_PRODUCT[7:0]});
    rdchk(4'h6, {8'h00, psd_pkg::ID_PRODUCT[15:8]});
    cmd(16'h0002);
    for (int i = 0; i < 6; i++)
      rdchk(4'h6, {8'h00, fw[47 - 8 * i -: 8]});
  endtask : t_id
  task automatic t_fail;
    cmd(16'h2857);
    cmd(16'h2812);
    cmd(16'h29a3);
    chk({15'h0, fail_out}, 16'h0000);
    cmd(16'h2857);
    repeat (55) @(negedge clock);
    cmd(16'h29a3);
    chk({15'h0, fail_out}, 16'h0000);
    psd_host_inst.fail_pair();
    @(negedge clock);
    chk({15'h0, fail_out}, 16'h0001);
    rdchk(4'h2, 16'h0030);
  endtask : t_fail
  initial begin
    rst_n                       = 1'b0;
    ocd_event                   = 1'b0;
    scd_event                   = 1'b0;
    load_detect_timeout_expired = 1'b0;
    errors                      = 0;
    checks_done                 = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk({7'h0, ocd_latch, scd_latch, load_pin, load_restart, chg_pin, dsg_pin, alert, fail_out, single}, 16'h001c);
    rdchk(4'h3, 16'h0008);
    t_latch;
    t_load_detect;
    t_gpo;
    t_link;
    t_id;
    t_fail;
    complete_run;
  end
  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    complete_run;
  end
endmodule : psd_decoder_tb

// File: tb/psd_host.sv
`timescale 1ns/10ps
module psd_host (
  input  wire logic        clock,
  output logic      [3:0]  address,
  output logic      [15:0] write_data,
  output logic             write_strobe,
  output logic             read_strobe,
  input  wire logic [15:0] read_data
);
  initial begin
    address      = 4'h0;
    write_data   = 16'h0000;
    write_strobe = 1'b0;
    read_strobe  = 1'b0;
  end
  // Each access leaves one idle edge, so a strobe is never raised in the step that lowers it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address      <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    address     <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    d = read_data;
  endtask : rd
  task automatic fail_pair;
    wr(4'h0, 16'h2857);
    wr(4'h0, 16'h29a3);
  endtask : fail_pair
endmodule : psd_host
